/* tb_triggered_pulse_generator.sv */
`timescale 1ns/10ps
module tb_triggered_pulse_generator;
    import tpg_pkg::*;
    logic mclk, sys_rst, reg_wr, reg_rd, trig, retrig, first_comparator, cmp2, cmp3;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic pulse_out, pulse_out_oe, secondary_pulse_output, gate_main, gate_aux, prev;
    logic [15:0] run_len, last_width;
    int num_errors, checks_done, pulse_count, n;
    logic [7:0] pat [6] = '{8'h32, 8'h33, 8'hAA, 8'h55, 8'h8D, 8'h12};
    logic [2:0] pexp [6] = '{3'b010, 3'b110, 3'b010, 3'b110, 3'b011, 3'b000};
    logic [7:0] mc [3] = '{8'h88, 8'h84, 8'h80};
    logic [7:0] pt [3] = '{8'hAA, 8'h8D, 8'hAA};
    logic [15:0] wexp [3] = '{16'h0010, 16'h0020, 16'h0010};

    tpg_pulse_gen dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trigger_source_edges(trig), .retrigger_active(retrig),
        .comparator1_output(first_comparator), .comparator2_output(cmp2),
        .comparator3_output(cmp3), .pulse_out(pulse_out), .pulse_out_oe(pulse_out_oe),
        .secondary_pulse_output(secondary_pulse_output));
    tpg_gate_shifter gate_u (.pulse_out(pulse_out), .pulse_out_oe(pulse_out_oe),
        .secondary_pulse_output(secondary_pulse_output), .gate_main(gate_main),
        .gate_aux(gate_aux));

    // 250 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // measures each high run on the gate; width is counted in mclk cycles
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            prev <= 1'b0;
            run_len <= 16'h0000;
            last_width <= 16'h0000;
            pulse_count <= 0;
        end
        else
        begin
            prev <= gate_main;
            if (gate_main)
                run_len <= (prev === 1'b1) ? run_len + 16'h0001 : 16'h0001;
            if (!gate_main && prev)
            begin
                last_width <= run_len;
                pulse_count <= pulse_count + 1;
            end
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    // bounded wait for the pulse count to reach a target, then settle
    task automatic wait_pulse(input int target);
        int k;
        k = 0;
        while (pulse_count < target && k < 2000)
        begin
            @(posedge mclk);
            k++;
        end
        @(negedge mclk);
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // a hang is cut off only far beyond the end of the whole sequence
    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        finish_test;
    end

    initial
    begin
        {reg_wr, reg_rd, retrig} = 3'h0;
        {trig, first_comparator, cmp2, cmp3, sys_rst} = 5'h1F;
        {reg_addr, reg_wdata} = '0;
        {num_errors, checks_done} = '0;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        // reset values, unmapped index
        rd_chk(ADDR_MAIN_CTRL, MAIN_CTRL_RST);
        rd_chk(ADDR_TRIG_DELAY, TRIG_DELAY_RST);
        rd_chk(ADDR_OUT_PATTERN, OUT_PATTERN_RST);
        rd_chk(ADDR_AUTO_INC, AUTO_INC_RD_MASK);
        rd_chk(5'h1F, 8'h00);
        check({15'h0000, pulse_out_oe}, 16'h0000);
        $display("test 1 done");
        // every output pattern code while idle
        for (int i = 0; i < 6; i++)
        begin
            wr(ADDR_OUT_PATTERN, pat[i]);
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            check({13'h0000, gate_main, pulse_out_oe, gate_aux}, {13'h0000, pexp[i]});
        end
        $display("test 2 done");
        // software pulses, both clock rates, ignored second start
        wr(ADDR_OUT_PATTERN, PAT_ACT_HIGH);
        wr(ADDR_NINTH_BITS, 8'h01);
        wr(ADDR_PRELOAD_A, 8'hF0);
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_OUT_PATTERN, pt[i]);
            n = pulse_count;
            wr(ADDR_MAIN_CTRL, mc[i]);
            rd_chk(ADDR_MAIN_CTRL, mc[i]);
            check({13'h0000, gate_main, pulse_out_oe, gate_aux}, 16'h0006);
            wr(ADDR_MAIN_CTRL, mc[i]);
            wait_pulse(n + 1);
            check(last_width, wexp[i]);
            repeat (40) @(posedge mclk);
            check(pulse_count, n + 1);
            rd_chk(ADDR_MAIN_CTRL, mc[i] & 8'h7F);
        end
        $display("test 3 done");
        // zero preload, software stop, reload after the stop
        wr(ADDR_NINTH_BITS, 8'h00);
        wr(ADDR_PRELOAD_A, 8'h00);
        wr(ADDR_MAIN_CTRL, 8'h88);
        repeat (10) @(posedge mclk);
        wr(ADDR_MAIN_CTRL, 8'h08);
        wait_pulse(pulse_count + 1);
        check({15'h0000, last_width < 16'h0020}, 16'h0001);
        rd_chk(ADDR_MAIN_CTRL, 8'h08);
        wr(ADDR_MAIN_CTRL, 8'h88);
        wait_pulse(pulse_count + 1);
        check(last_width, 16'h0200);
        $display("test 4 done");
        // hardware trigger, retrigger, restart blocked by comparator 2
        wr(ADDR_NINTH_BITS, 8'h01);
        wr(ADDR_PRELOAD_A, 8'hF0);
        wr(ADDR_TRIG_DELAY, 8'h00);
        wr(ADDR_MAIN_CTRL, 8'h48);
        n = pulse_count;
        trig <= 1'b0;
        wait_pulse(n + 1);
        check(last_width, 16'h0010);
        trig <= 1'b1;
        @(posedge mclk);
        retrig <= 1'b1;
        @(posedge mclk);
        retrig <= 1'b0;
        wait_pulse(n + 2);
        check(pulse_count, n + 2);
        cmp2 <= 1'b0;
        repeat (6) @(posedge mclk);
        rd_chk(ADDR_MAIN_CTRL, 8'h08);
        trig <= 1'b0;
        repeat (40) @(posedge mclk);
        check(pulse_count, n + 2);
        {trig, cmp2} <= 2'b11;
        $display("test 5 done");
        // comparator 3 stops a running pulse
        wr(ADDR_NINTH_BITS, 8'h00);
        wr(ADDR_PRELOAD_A, 8'h00);
        wr(ADDR_MAIN_CTRL, 8'hE8);
        repeat (20) @(posedge mclk);
        cmp3 <= 1'b0;
        wait_pulse(pulse_count + 1);
        check({15'h0000, last_width < 16'h0040}, 16'h0001);
        rd_chk(ADDR_MAIN_CTRL, 8'h28);
        cmp3 <= 1'b1;
        $display("test 6 done");
        // comparator 1 switches reloads to preload B
        wr(ADDR_NINTH_BITS, 8'h11);
        wr(ADDR_PRELOAD_A, 8'hF0);
        wr(ADDR_PRELOAD_B, 8'hE0);
        wr(ADDR_MAIN_CTRL, 8'h09);
        first_comparator <= 1'b0;
        repeat (6) @(posedge mclk);
        rd_chk(ADDR_MAIN_CTRL, 8'h19);
        first_comparator <= 1'b1;
        wr(ADDR_MAIN_CTRL, 8'h99);
        wait_pulse(pulse_count + 1);
        check(last_width, 16'h0020);
        rd_chk(ADDR_MAIN_CTRL, 8'h19);
        $display("test 7 done");
        // auto-increment saturates, writes blocked while comparator 1 low
        wr(ADDR_MAIN_CTRL, 8'h08);
        wr(ADDR_AUTO_INC, 8'h01);
        repeat (6) @(posedge mclk);
        rd_chk(ADDR_PRELOAD_A, 8'hF0);
        first_comparator <= 1'b0;
        repeat (200) @(posedge mclk);
        rd_chk(ADDR_PRELOAD_A, 8'hFF);
        rd_chk(ADDR_NINTH_BITS, 8'h11);
        wr(ADDR_PRELOAD_A, 8'h10);
        rd_chk(ADDR_PRELOAD_A, 8'hFF);
        first_comparator <= 1'b1;
        $display("test 8 done");
        finish_test;
    end
endmodule // tb_triggered_pulse_generator

/* tpg_gate_shifter.sv */
`timescale 1ns/10ps
// far-side level shifter feeding the power switch gates
module tpg_gate_shifter
#(
    parameter logic PULL_HIGH = 1'b0
)
(
    input wire logic pulse_out,
    input wire logic pulse_out_oe,
    input wire logic secondary_pulse_output,
    output logic gate_main,
    output logic gate_aux
);
    // released pin settles to the external pull resistor, never the last level
    assign gate_main = pulse_out_oe ? pulse_out : PULL_HIGH;
    // secondary line is always driven by the device
    assign gate_aux = secondary_pulse_output;
endmodule // tpg_gate_shifter

/* tpg_pkg.sv */
package tpg_pkg;
    // register indices on the plain register port
    localparam logic [4:0] ADDR_MAIN_CTRL = 5'h00;
    localparam logic [4:0] ADDR_TRIG_DELAY = 5'h01;
    localparam logic [4:0] ADDR_AUTO_INC = 5'h02;
    localparam logic [4:0] ADDR_PRELOAD_A = 5'h03;
    localparam logic [4:0] ADDR_PRELOAD_B = 5'h04;
    localparam logic [4:0] ADDR_APPROACH_C = 5'h05;
    localparam logic [4:0] ADDR_APPROACH_D = 5'h06;
    localparam logic [4:0] ADDR_NINTH_BITS = 5'h07;
    localparam logic [4:0] ADDR_OUT_PATTERN = 5'h09;
    localparam logic [4:0] ADDR_ADJUST0 = 5'h0A;
    localparam logic [4:0] ADDR_ADJUST1 = 5'h0B;
    // main control bit positions
    localparam int MC_SW_TRIG = 7;
    localparam int MC_RESTART_EN = 6;
    localparam int MC_CMP_STOP_EN = 5;
    localparam int MC_RELOAD_SEL = 4;
    localparam int MC_START_ASYNC = 3;
    localparam int MC_CLK_HALF = 2;
    localparam int MC_ALT_RELOAD_EN = 0;
    // auto-increment control fields
    localparam int AI_INTERVAL_SEL = 4;
    // adjust control 0 fields
    localparam int AJ_STEP_EN = 7;
    localparam int AJ_STEP_MODE = 6;
    localparam int AJ_TMODE_LSB = 2;
    // ninth-bit positions in the extension register
    localparam int NB_A = 0;
    localparam int NB_C = 2;
    localparam int NB_B = 4;
    localparam int NB_D = 6;
    // reset values and the auto-increment read mask
    localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
    localparam logic [7:0] TRIG_DELAY_RST = 8'h80;
    localparam logic [7:0] AUTO_INC_RST = 8'h00;
    localparam logic [7:0] OUT_PATTERN_RST = 8'h00;
    localparam logic [7:0] AUTO_INC_RD_MASK = 8'hE0;
    // output pattern codes
    localparam logic [7:0] PAT_ACT_LOW = 8'h55;
    localparam logic [7:0] PAT_ACT_HIGH = 8'hAA;
    localparam logic [7:0] PAT_FORCE_LOW = 8'h32;
    localparam logic [7:0] PAT_FORCE_HIGH = 8'h33;
    localparam logic [7:0] PAT_DUAL = 8'h8D;
    // counter limits and timing
    localparam logic [8:0] CNT_ALL_ONES = 9'h1FF;
    localparam logic [5:0] DELAY_MAX = 6'h30;
    localparam logic [3:0] INC_PERIOD_SHORT = 4'h7;
    localparam logic [3:0] INC_PERIOD_LONG = 4'hF;
endpackage

/* tpg_pulse_gen.sv */
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Contract
// R1: one 9-bit pulse channel counting up from preload, period up to 512 ticks.
// R2: count starts at preload and ends wrapping from 1FF to 000.
// R3: preload value zero gives the full 512-tick pulse.
// R4: overflow reloads counter from active preload and stops the timer.
// R5: switching off or any stop also reloads the counter.
// R6: select flag picks preload A or B; comparator 1 fall sets it if enabled.
// R7: with restart enable, delayed trigger, retrigger or software bit starts pulse.
// R8: comparator 2 or 3 falling edge clears restart enable.
// R9: software bit one starts, zero stops; hardware clears it on stop.
// R10: triggers while counting are ignored.
// R11: reading the software bit shows whether the pulse is active.
// R12: pattern 55h gives active-low, AAh gives active-high output.
// R13: pattern 32h forces output low, 33h forces it high.
// R14: pattern 8Dh active-high idle-low; undefined codes float the output.
// R15: secondary output stays low unless the pattern is 8Dh.
// R16: a bit selects synchronised or unsynchronised counter start.
// R17: nonzero step adds to preload A every 8 or 16 clocks, saturating.
// R18: software sets comparator 1 high before writing auto-increment control.
// R19: comparator 1 low with nonzero step blocks writes to preload A.
// R20: comparator 1 high locks preload A and adjust fields in two modes.
// R21: each accepted trigger gives exactly one pulse.
// R22: counter clock is system clock or half of it.
// R23: with stop enable, comparator 2 or 3 fall stops the pulse.
// R24: preload A increments only while comparator 1 is low.
// R25: trigger source edges during the delay period are ignored.
// R26: counter advances one per tick while running, holds when stopped; the code reloads it from the active preload while stopped.
// R27: reset restores control defaults, timer stopped, software bit clear.
module tpg_pulse_gen
    import tpg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic trigger_source_edges,
    input wire logic retrigger_active,
    input wire logic comparator1_output,
    input wire logic comparator2_output,
    input wire logic comparator3_output,
    output logic pulse_out,
    output logic pulse_out_oe,
    output logic secondary_pulse_output
);
    logic [7:0] main_ctrl;
    logic [7:0] trig_delay;
    logic [7:0] auto_inc;
    logic [8:0] preload_a;
    logic [8:0] preload_b;
    logic [8:0] approach_c;
    logic [8:0] approach_d;
    logic [7:0] pattern;
    logic [7:0] adjust0;
    logic [7:0] adjust1;
    logic [8:0] count;
    logic running;
    logic tick_half;
    logic [2:0] trg_sync;
    logic [2:0] c1_sync;
    logic [2:0] c2_sync;
    logic [2:0] c3_sync;
    logic [5:0] delay_cnt;
    logic delay_busy;
    logic delayed_hw_trigger;
    logic [3:0] inc_div;
    logic start_pend;

    // synchronised pins; stage 0 feeds only stage 1
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            trg_sync <= 3'h7;
            c1_sync <= 3'h7;
            c2_sync <= 3'h7;
            c3_sync <= 3'h7;
        end
        else
        begin
            trg_sync <= {trg_sync[1:0], trigger_source_edges};
            c1_sync <= {c1_sync[1:0], comparator1_output};
            c2_sync <= {c2_sync[1:0], comparator2_output};
            c3_sync <= {c3_sync[1:0], comparator3_output};
        end
    end

    logic trg_fall;
    logic c1_fall;
    logic c23_fall;
    logic c1_level;
    assign trg_fall = trg_sync[2] & ~trg_sync[1];
    assign c1_fall = c1_sync[2] & ~c1_sync[1];
    assign c23_fall = (c2_sync[2] & ~c2_sync[1]) | (c3_sync[2] & ~c3_sync[1]);
    assign c1_level = c1_sync[1];

    // trigger delay; edges inside the window are dropped
    logic [5:0] delay_len;
    assign delay_len = (trig_delay[5:0] > DELAY_MAX) ? DELAY_MAX : trig_delay[5:0];
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            delay_cnt <= 6'h00;
            delay_busy <= 1'b0;
            delayed_hw_trigger <= 1'b0;
        end
        else
        begin
            delayed_hw_trigger <= 1'b0;
            if (delay_busy)
            begin
                if (delay_cnt <= 6'h01)
                begin
                    delay_busy <= 1'b0;
                    delayed_hw_trigger <= 1'b1;
                end
                else
                    delay_cnt <= delay_cnt - 6'h01;
            end
            else if (trg_fall) // see R25
            begin
                if (delay_len == 6'h00)
                    delayed_hw_trigger <= 1'b1;
                else
                begin
                    delay_busy <= 1'b1;
                    delay_cnt <= delay_len;
                end
            end
        end
    end

    // counter clock: every edge or every other edge
    logic tick;
    assign tick = ~main_ctrl[MC_CLK_HALF] | tick_half; // see R22
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            tick_half <= 1'b0;
        else
            tick_half <= ~tick_half;
    end

    // start and stop decisions
    logic sw_start;
    logic sw_stop;
    logic hw_start;
    logic do_start;
    logic overflow;
    logic cmp_stop;
    logic stop_any;
    logic wr_main;
    assign wr_main = reg_wr && reg_addr == ADDR_MAIN_CTRL;
    assign sw_start = wr_main && reg_wdata[MC_SW_TRIG]; // see R9
    assign sw_stop = wr_main && !reg_wdata[MC_SW_TRIG] && (running || start_pend); // see R9
    assign hw_start = main_ctrl[MC_RESTART_EN] && (delayed_hw_trigger || retrigger_active); // see R7
    assign do_start = !running && !start_pend && (sw_start || hw_start); // see R10 R21
    assign overflow = running && tick && count == CNT_ALL_ONES; // see R2
    assign cmp_stop = running && main_ctrl[MC_CMP_STOP_EN] && c23_fall; // see R23
    assign stop_any = overflow || cmp_stop || sw_stop;

    logic [8:0] active_preload;
    assign active_preload = main_ctrl[MC_RELOAD_SEL] ? preload_b : preload_a; // see R6

    // run state; synchronised start waits for the next tick
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            running <= 1'b0;
            start_pend <= 1'b0;
        end
        else if (stop_any)
        begin
            running <= 1'b0; // see R4
            start_pend <= 1'b0;
        end
        else if (do_start && (main_ctrl[MC_START_ASYNC] || tick)) // see R16
            running <= 1'b1;
        else if (do_start)
            start_pend <= 1'b1;
        else if (start_pend && tick)
        begin
            start_pend <= 1'b0;
            running <= 1'b1;
        end
    end

    // 9-bit up-counter; zero preload yields 512 ticks
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            count <= 9'h000;
        else if (stop_any || !running && !start_pend && !do_start)
            count <= active_preload; // see R4 R5 R3
        else if (running && tick)
            count <= count + 9'h001; // see R26 R1
    end

    // main control: hardware set/clear wins over software write
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            main_ctrl <= MAIN_CTRL_RST; // see R27
        else
        begin
            if (wr_main)
                main_ctrl <= reg_wdata;
            if (stop_any)
                main_ctrl[MC_SW_TRIG] <= 1'b0; // see R9
            else if (do_start)
                main_ctrl[MC_SW_TRIG] <= 1'b1;
            else if (wr_main)
                main_ctrl[MC_SW_TRIG] <= running;
            if (c23_fall)
                main_ctrl[MC_RESTART_EN] <= 1'b0; // see R8
            if (main_ctrl[MC_ALT_RELOAD_EN] && c1_fall)
                main_ctrl[MC_RELOAD_SEL] <= 1'b1; // see R6
        end
    end

    // write locks on preload A and adjust fields
    logic lock_a_low;
    logic lock_adj;
    logic [1:0] tmode;
    assign tmode = adjust0[AJ_TMODE_LSB +: 2];
    assign lock_a_low = !c1_level && auto_inc[3:0] != 4'h0; // see R19
    assign lock_adj = c1_level && ((!adjust0[AJ_STEP_MODE] && adjust0[AJ_STEP_EN])
        || (adjust0[AJ_STEP_MODE] && (tmode == 2'h1 || tmode == 2'h2))); // see R20

    // auto-increment interval divider
    logic inc_now;
    assign inc_now = inc_div == (auto_inc[AI_INTERVAL_SEL] ? INC_PERIOD_LONG : INC_PERIOD_SHORT);
    always_ff @(posedge mclk)
    begin
        if (sys_rst || !lock_a_low)
            inc_div <= 4'h0;
        else if (inc_now)
            inc_div <= 4'h0;
        else
            inc_div <= inc_div + 4'h1;
    end

    // preload A with saturating auto-increment
    logic [9:0] a_sum;
    assign a_sum = {1'b0, preload_a} + {6'h00, auto_inc[3:0]};
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            preload_a <= 9'h000;
        else if (lock_a_low && inc_now && preload_a != CNT_ALL_ONES) // see R17 R24
            preload_a <= a_sum[9] ? CNT_ALL_ONES : a_sum[8:0];
        else if (reg_wr && !lock_a_low && !lock_adj)
        begin
            if (reg_addr == ADDR_PRELOAD_A)
                preload_a[7:0] <= reg_wdata;
            else if (reg_addr == ADDR_NINTH_BITS)
                preload_a[8] <= reg_wdata[NB_A];
        end
    end

    // remaining software registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            trig_delay <= TRIG_DELAY_RST;
            auto_inc <= AUTO_INC_RST;
            preload_b <= 9'h000;
            approach_c <= 9'h000;
            approach_d <= 9'h000;
            pattern <= OUT_PATTERN_RST;
            adjust0 <= 8'h00;
            adjust1 <= 8'h00;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                ADDR_TRIG_DELAY: trig_delay <= reg_wdata;
                ADDR_AUTO_INC: auto_inc <= {3'h0, reg_wdata[4:0]};
                ADDR_PRELOAD_B: preload_b[7:0] <= reg_wdata;
                ADDR_APPROACH_C: approach_c[7:0] <= reg_wdata;
                ADDR_APPROACH_D: approach_d[7:0] <= reg_wdata;
                ADDR_NINTH_BITS:
                begin
                    preload_b[8] <= reg_wdata[NB_B];
                    approach_c[8] <= reg_wdata[NB_C];
                    approach_d[8] <= reg_wdata[NB_D];
                end
                ADDR_OUT_PATTERN: pattern <= reg_wdata;
                ADDR_ADJUST0: adjust0 <= reg_wdata;
                ADDR_ADJUST1:
                begin
                    if (!lock_adj) // see R20
                        adjust1 <= reg_wdata;
                end
                default: ;
            endcase
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                ADDR_MAIN_CTRL: reg_rdata <= {running, main_ctrl[6:0]}; // see R11
                ADDR_TRIG_DELAY: reg_rdata <= trig_delay;
                ADDR_AUTO_INC: reg_rdata <= auto_inc | AUTO_INC_RD_MASK;
                ADDR_PRELOAD_A: reg_rdata <= preload_a[7:0];
                ADDR_PRELOAD_B: reg_rdata <= preload_b[7:0];
                ADDR_APPROACH_C: reg_rdata <= approach_c[7:0];
                ADDR_APPROACH_D: reg_rdata <= approach_d[7:0];
                ADDR_NINTH_BITS: reg_rdata <= {1'b0, approach_d[8], 1'b0, preload_b[8],
                    1'b0, approach_c[8], 1'b0, preload_a[8]};
                ADDR_OUT_PATTERN: reg_rdata <= pattern;
                ADDR_ADJUST0: reg_rdata <= adjust0;
                ADDR_ADJUST1: reg_rdata <= adjust1;
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // running level as it will be after this edge, so pin tracks the counter
    logic next_run;
    assign next_run = running && !stop_any
        || (do_start && (main_ctrl[MC_START_ASYNC] || tick)) || (start_pend && tick && !stop_any);

    // output stage, registered; undefined patterns release the pin
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pulse_out <= 1'b0;
            pulse_out_oe <= 1'b0;
            secondary_pulse_output <= 1'b0;
        end
        else
        begin
            pulse_out_oe <= 1'b1;
            secondary_pulse_output <= 1'b0; // see R15
            unique case (pattern)
                PAT_ACT_LOW: pulse_out <= ~next_run; // see R12
                PAT_ACT_HIGH: pulse_out <= next_run;
                PAT_FORCE_LOW: pulse_out <= 1'b0; // see R13
                PAT_FORCE_HIGH: pulse_out <= 1'b1;
                PAT_DUAL:
                begin
                    pulse_out <= next_run; // see R14
                    secondary_pulse_output <= ~next_run;
                end
                default:
                begin
                    pulse_out <= 1'b0;
                    pulse_out_oe <= 1'b0; // see R14
                end
            endcase
        end
    end

    // assertions
    a_overflow_stops: assert property (@(posedge mclk) disable iff (sys_rst)
        overflow |=> !running && count == active_preload) // see R4
        else $error("overflow did not stop and reload");
    a_status_tracks_run: assert property (@(posedge mclk) disable iff (sys_rst)
        stop_any |=> !main_ctrl[MC_SW_TRIG]) // see R9
        else $error("software bit not cleared on stop");
    a_restart_cleared: assert property (@(posedge mclk) disable iff (sys_rst)
        c23_fall |=> !main_ctrl[MC_RESTART_EN]) // see R8
        else $error("restart enable not cleared");
    a_ignore_while_run: assert property (@(posedge mclk) disable iff (sys_rst)
        running && !stop_any && tick |=> count == $past(count) + 9'h001) // see R10
        else $error("count disturbed while running");
    a_reload_b_sel: assert property (@(posedge mclk) disable iff (sys_rst)
        main_ctrl[MC_ALT_RELOAD_EN] && c1_fall |=> main_ctrl[MC_RELOAD_SEL]) // see R6
        else $error("reload select not set");
    a_secondary_low: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(pattern) != PAT_DUAL |-> !secondary_pulse_output) // see R15
        else $error("secondary output not low");
    a_force_high: assert property (@(posedge mclk) disable iff (sys_rst)
        pattern == PAT_FORCE_HIGH ##1 pattern == PAT_FORCE_HIGH |-> pulse_out) // see R13
        else $error("force high failed");
    a_lock_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && reg_addr == ADDR_PRELOAD_A && lock_a_low && !inc_now
        |=> preload_a == $past(preload_a)) // see R19
        else $error("preload A write not blocked");
    a_inc_saturate: assert property (@(posedge mclk) disable iff (sys_rst)
        preload_a == CNT_ALL_ONES && lock_a_low |=> preload_a == CNT_ALL_ONES) // see R17
        else $error("preload A passed all ones");
endmodule // tpg_pulse_gen
